// ---- rtl/ohi_pkg.sv ----
// Package: shared constants and types for the display host interface
package ohi_pkg;
  // Interface strap codes {iface_sel_high, iface_sel_low}
  localparam logic [1:0] SEL_SERIAL = 2'h0;
  localparam logic [1:0] SEL_I2C = 2'h1;
  localparam logic [1:0] SEL_6800 = 2'h2;
  localparam logic [1:0] SEL_8080 = 2'h3;
  // Data bus bit positions used in serial mode
  localparam int SCLK_BIT = 0;
  localparam int SERIAL_IN_LINE_BIT = 1;
  localparam int BYTE_W = 8;
  // Scan period marker: lines per frame and clocks per line
  localparam int LINE_CLKS = 16;
  localparam int FRAME_LINES = 64;
  // Host strobe timing, in clocks
  localparam int STROBE_CLKS = 4;
  // I2C base address, upper six bits; arbitrary value
  localparam logic [5:0] I2C_ADDR_HI = 6'h1E;
  typedef enum {IFM_SERIAL, IFM_I2C, IFM_6800, IFM_8080} ohi_mode_type;
  typedef enum {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD} ohi_host_state_type;
endpackage

// ---- rtl/ohi_if.sv ----
// Interface: pin bundle between the host and the display controller
`timescale 1ns/10ps
`default_nettype none
interface ohi_if;
  logic iface_sel_low;
  logic iface_sel_high;
  logic cmd_or_data_sel;
  logic select_n;
  logic init_n;
  logic enable_rd_n;
  logic dir_wr_n;
  logic [7:0] data_host;
  logic [7:0] data_host_oe_n;
  logic [7:0] data_dev;
  logic [7:0] data_dev_oe_n;
  logic scan_period_marker;
  modport dev (
    input iface_sel_low, iface_sel_high, cmd_or_data_sel, select_n, init_n,
    input enable_rd_n, dir_wr_n, data_host, data_host_oe_n,
    output data_dev, data_dev_oe_n, scan_period_marker
  );
  modport host (
    output iface_sel_low, iface_sel_high, cmd_or_data_sel, select_n, init_n,
    output enable_rd_n, dir_wr_n, data_host, data_host_oe_n,
    input data_dev, data_dev_oe_n, scan_period_marker
  );
endinterface
`default_nettype wire

// ---- rtl/ohi_device.sv ----
// Device end: protocol select, byte capture and frame marker
`timescale 1ns/10ps
`default_nettype none
module ohi_device (
  input wire logic i_clk,
  input wire logic i_arst_n,
  ohi_if.dev pins,
  input wire logic [7:0] i_read_data,
  output logic [7:0] o_data,
  output logic o_data_valid,
  output logic [7:0] o_cmd,
  output logic o_cmd_valid,
  output logic o_read_taken,
  output logic o_in_init,
  output logic [1:0] o_mode,
  output logic [6:0] o_i2c_addr
);
  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops before any logic looks
  localparam int SW = 14;
  logic [SW-1:0] raw;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [SW-1:0] s3_reg;
  assign raw = {pins.iface_sel_high, pins.iface_sel_low, pins.cmd_or_data_sel,
                pins.select_n, pins.enable_rd_n, pins.dir_wr_n, pins.data_host};
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_reg <= {SW{1'b1}};
      s2_reg <= {SW{1'b1}};
      s3_reg <= {SW{1'b1}};
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  logic [7:0] d_s;
  logic dc_s;
  logic sel_n_s;
  logic en_s;
  logic en_d;
  logic dir_s;
  logic dir_d;
  assign d_s = s2_reg[7:0];
  assign dir_s = s2_reg[8];
  assign dir_d = s3_reg[8];
  assign en_s = s2_reg[9];
  assign en_d = s3_reg[9];
  assign sel_n_s = s2_reg[10];
  assign dc_s = s2_reg[11];

  //////////////////////////////////////////////////////////////////////////
  // Init and strap capture; straps latched while init is low
  logic init_s1_reg;
  logic init_reg;
  logic [1:0] mode_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_s1_reg <= 1'b0;
      init_reg <= 1'b0;
    end else begin
      init_s1_reg <= pins.init_n;
      init_reg <= init_s1_reg;
    end
  end
  // Latching during init keeps a glitching strap from switching protocol
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_reg <= ohi_pkg::SEL_8080;
    end else if (!init_reg) begin
      mode_reg <= s2_reg[13:12];
    end
  end
  assign o_mode = mode_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_in_init <= 1'b1;
    end else begin
      o_in_init <= !init_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transfer start detection per protocol
  logic active;
  logic wr_go;
  logic rd_go;
  logic sclk_rise;
  assign active = init_reg && !sel_n_s;
  always_comb begin
    wr_go = 1'b0;
    rd_go = 1'b0;
    case (mode_reg)
      ohi_pkg::SEL_6800: begin
        wr_go = active && en_s && !en_d && !dir_s;
        rd_go = active && en_s && !en_d && dir_s;
      end
      ohi_pkg::SEL_8080: begin
        wr_go = active && dir_d && !dir_s;
        rd_go = active && !en_s && en_d;
      end
      default: begin
        wr_go = 1'b0;
        rd_go = 1'b0;
      end
    endcase
  end
  assign sclk_rise = s2_reg[ohi_pkg::SCLK_BIT] && !s3_reg[ohi_pkg::SCLK_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Serial shifter, MSB first
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic ser_done;
  assign ser_done = (mode_reg == ohi_pkg::SEL_SERIAL) && active && sclk_rise
                    && (bit_reg == 3'h7);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_reg <= 8'h00;
      bit_reg <= 3'h0;
    end else if (mode_reg != ohi_pkg::SEL_SERIAL || !active) begin
      bit_reg <= 3'h0;
    end else if (sclk_rise) begin
      sh_reg <= {sh_reg[6:0], d_s[ohi_pkg::SERIAL_IN_LINE_BIT]};
      bit_reg <= bit_reg + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Byte routing to data or command
  logic [7:0] byte_w;
  logic byte_go;
  assign byte_go = wr_go || ser_done;
  assign byte_w = ser_done ? {sh_reg[6:0], d_s[ohi_pkg::SERIAL_IN_LINE_BIT]} : d_s;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= 8'h00;
      o_data_valid <= 1'b0;
      o_cmd <= 8'h00;
      o_cmd_valid <= 1'b0;
    end else begin
      o_data_valid <= byte_go && dc_s;
      o_cmd_valid <= byte_go && !dc_s;
      if (byte_go && dc_s) begin
        o_data <= byte_w;
      end
      if (byte_go && !dc_s) begin
        o_cmd <= byte_w;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read return: drive bus while read strobe active
  logic rd_on;
  assign rd_on = active && ((mode_reg == ohi_pkg::SEL_6800 && en_s && dir_s)
                 || (mode_reg == ohi_pkg::SEL_8080 && !en_s));
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pins.data_dev <= 8'h00;
      pins.data_dev_oe_n <= 8'hFF;
      o_read_taken <= 1'b0;
    end else begin
      o_read_taken <= rd_go;
      if (rd_go) begin
        pins.data_dev <= i_read_data;
      end
      pins.data_dev_oe_n <= rd_on ? 8'h00 : 8'hFF;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // I2C address; the data/command pin supplies bit 0
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_i2c_addr <= 7'h00;
    end else begin
      o_i2c_addr <= {ohi_pkg::I2C_ADDR_HI, (mode_reg == ohi_pkg::SEL_I2C) && dc_s};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame marker: high during the first half of each frame
  logic [3:0] clk_cnt_reg;
  logic [5:0] line_cnt_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_cnt_reg <= 4'h0;
      line_cnt_reg <= 6'h00;
      pins.scan_period_marker <= 1'b0;
    end else if (!init_reg) begin
      clk_cnt_reg <= 4'h0;
      line_cnt_reg <= 6'h00;
      pins.scan_period_marker <= 1'b0;
    end else begin
      clk_cnt_reg <= clk_cnt_reg + 4'h1;
      if (clk_cnt_reg == 4'(ohi_pkg::LINE_CLKS - 1)) begin
        line_cnt_reg <= line_cnt_reg + 6'h01;
      end
      pins.scan_period_marker <= !line_cnt_reg[5];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/ohi_host.sv ----
// Host end: drives straps, select, strobes and serial lines
`timescale 1ns/10ps
`default_nettype none
module ohi_host (
  input wire logic i_clk,
  input wire logic i_arst_n,
  ohi_if.host pins,
  input wire logic [1:0] i_mode,
  input wire logic i_init_req,
  input wire logic i_req,
  input wire logic i_rd,
  input wire logic i_is_data,
  input wire logic [7:0] i_byte,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rd_data
);
  //////////////////////////////////////////////////////////////////////////
  // Straps carry no reset so they already stand when reset lifts
  logic [1:0] strap_reg;
  logic is_par;
  logic en_idle;
  logic dir_idle;
  logic [7:0] oe_idle;
  always_ff @(posedge i_clk) begin
    strap_reg <= i_mode;
  end
  assign pins.iface_sel_low = strap_reg[0];
  assign pins.iface_sel_high = strap_reg[1];
  assign is_par = (strap_reg == ohi_pkg::SEL_6800) || (strap_reg == ohi_pkg::SEL_8080);
  assign en_idle = (strap_reg == ohi_pkg::SEL_8080);
  assign dir_idle = is_par;
  // Serial drives every line; the unused ones are held low
  assign oe_idle = (strap_reg == ohi_pkg::SEL_SERIAL) ? 8'h00 : 8'hFF;

  //////////////////////////////////////////////////////////////////////////
  // Init pulse, released right after reset
  logic [3:0] init_cnt_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_cnt_reg <= 4'h0;
      pins.init_n <= 1'b0;
    end else if (i_init_req) begin
      init_cnt_reg <= 4'(ohi_pkg::STROBE_CLKS);
      pins.init_n <= 1'b0;
    end else begin
      if (init_cnt_reg != 4'h0) begin
        init_cnt_reg <= init_cnt_reg - 4'h1;
      end
      pins.init_n <= (init_cnt_reg < 4'h2);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transfer sequencer: setup, strobe, hold, each a fixed phase; the serial strobe runs two phases per bit
  // Hold keeps select low until the device has released the bus
  localparam logic [3:0] PH_LAST = 4'(ohi_pkg::STROBE_CLKS - 1);
  ohi_pkg::ohi_host_state_type state_reg;
  logic [3:0] cnt_reg;
  logic [2:0] bit_reg;
  logic phase_reg;
  logic rd_reg;
  logic [7:0] shift_reg;
  logic ph_end;
  assign ph_end = (cnt_reg == PH_LAST);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ohi_pkg::HS_IDLE;
      cnt_reg <= 4'h0;
      bit_reg <= 3'h0;
      phase_reg <= 1'b0;
      rd_reg <= 1'b0;
      shift_reg <= 8'h00;
      pins.select_n <= 1'b1;
      pins.enable_rd_n <= 1'b1;
      pins.dir_wr_n <= 1'b1;
      pins.cmd_or_data_sel <= 1'b0;
      pins.data_host <= 8'h00;
      pins.data_host_oe_n <= 8'hFF;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      case (state_reg)
        ohi_pkg::HS_IDLE: begin
          o_done <= 1'b0;
          cnt_reg <= 4'h0;
          pins.select_n <= 1'b1;
          pins.enable_rd_n <= en_idle;
          pins.dir_wr_n <= dir_idle;
          pins.data_host <= 8'h00;
          pins.data_host_oe_n <= oe_idle;
          // No two-wire engine here: such a request ends at once
          if (i_req && strap_reg == ohi_pkg::SEL_I2C) begin
            o_done <= 1'b1;
          end else if (i_req) begin
            o_busy <= 1'b1;
            rd_reg <= i_rd;
            shift_reg <= i_byte;
            pins.select_n <= 1'b0;
            pins.cmd_or_data_sel <= i_is_data;
            if (is_par) begin
              pins.data_host <= i_byte;
              pins.data_host_oe_n <= i_rd ? 8'hFF : 8'h00;
              if (strap_reg == ohi_pkg::SEL_6800) begin
                pins.dir_wr_n <= i_rd;
              end
            end
            state_reg <= ohi_pkg::HS_SETUP;
          end
        end
        ohi_pkg::HS_SETUP: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (ph_end) begin
            cnt_reg <= 4'h0;
            bit_reg <= 3'h0;
            phase_reg <= 1'b0;
            state_reg <= ohi_pkg::HS_STROBE;
            if (strap_reg == ohi_pkg::SEL_6800) begin
              pins.enable_rd_n <= 1'b1;
            end else if (strap_reg == ohi_pkg::SEL_8080) begin
              if (rd_reg) begin
                pins.enable_rd_n <= 1'b0;
              end else begin
                pins.dir_wr_n <= 1'b0;
              end
            end else begin
              pins.data_host[ohi_pkg::SERIAL_IN_LINE_BIT] <= shift_reg[7];
            end
          end
        end
        ohi_pkg::HS_STROBE: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (ph_end) begin
            cnt_reg <= 4'h0;
            if (is_par) begin
              if (rd_reg) begin
                o_rd_data <= pins.data_dev;
              end
              pins.enable_rd_n <= en_idle;
              if (strap_reg == ohi_pkg::SEL_8080) begin
                pins.dir_wr_n <= 1'b1;
              end
              state_reg <= ohi_pkg::HS_HOLD;
            end else if (!phase_reg) begin
              phase_reg <= 1'b1;
              pins.data_host[ohi_pkg::SCLK_BIT] <= 1'b1;
            end else begin
              phase_reg <= 1'b0;
              pins.data_host[ohi_pkg::SCLK_BIT] <= 1'b0;
              if (bit_reg == 3'h7) begin
                pins.data_host <= 8'h00;
                state_reg <= ohi_pkg::HS_HOLD;
              end else begin
                bit_reg <= bit_reg + 3'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                pins.data_host[ohi_pkg::SERIAL_IN_LINE_BIT] <= shift_reg[6];
              end
            end
          end
        end
        ohi_pkg::HS_HOLD: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (ph_end) begin
            cnt_reg <= 4'h0;
            pins.select_n <= 1'b1;
            o_done <= 1'b1;
            o_busy <= 1'b0;
            state_reg <= ohi_pkg::HS_IDLE;
          end
        end
        default: begin
          state_reg <= ohi_pkg::HS_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verif/ohi_asserts.sv ----
// Checker: pin rules between the host and display ends
`timescale 1ns/10ps
`default_nettype none
module ohi_asserts (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic iface_sel_low,
  input wire logic iface_sel_high,
  input wire logic select_n,
  input wire logic init_n,
  input wire logic enable_rd_n,
  input wire logic dir_wr_n,
  input wire logic [7:0] data_host_oe_n,
  input wire logic [7:0] data_dev_oe_n,
  input wire logic scan_period_marker
);
  wire logic [1:0] sel = {iface_sel_high, iface_sel_low};
  logic [11:0] still_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Idle time of the marker; init may halt the scan
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      still_reg <= 12'h000;
    end else if (!init_n || $changed(scan_period_marker)) begin
      still_reg <= 12'h000;
    end else if (still_reg != 12'hFFF) begin
      still_reg <= still_reg + 12'h001;
    end
  end
  ////////////////////////////////////////
  sequence s_wr_start;
    sel == ohi_pkg::SEL_8080 ##0 $fell(dir_wr_n);
  endsequence
  sequence s_en_start;
    sel == ohi_pkg::SEL_6800 ##0 $rose(enable_rd_n);
  endsequence
  a_straps_held: assert property ($past(i_arst_n, 3) |-> $stable(sel))
    else $error("strap pins moved");
  a_quiet_deselect: assert property (select_n ##1 select_n |-> &data_dev_oe_n)
    else $error("bus driven while deselected");
  a_no_bus_clash: assert property (&(data_host_oe_n | data_dev_oe_n))
    else $error("both ends drive the bus");
  a_serial_silent: assert property (sel == ohi_pkg::SEL_SERIAL |-> &data_dev_oe_n)
    else $error("bus driven in serial mode");
  a_write_selected: assert property (s_wr_start |-> !select_n)
    else $error("store strobe while deselected");
  a_enable_selected: assert property (s_en_start |-> !select_n)
    else $error("enable strobe while deselected");
  a_marker_alive: assert property (still_reg < 12'hA00)
    else $error("scan marker stuck");
  a_init_silent: assert property (!init_n |-> &data_dev_oe_n)
    else $error("bus driven during init");
endmodule
`default_nettype wire

// ---- verif/oled_host_interface_select_bench.sv ----
// Testbench: host and display ends joined, driven from the host user side
`timescale 1ns/10ps
`default_nettype none
module oled_host_interface_select_bench;
  logic clk = 1'b0, arst_n = 1'b0, init_req = 1'b0, req = 1'b0, rd = 1'b0, is_data = 1'b0;
  logic d_valid, c_valid, in_init, done;
  logic [1:0] mode = 2'h0;
  logic [1:0] dmode;
  logic [7:0] byte_in = 8'h00, rdata = 8'h00;
  logic [7:0] d_data, c_cmd, rd_data, got_d, got_c;
  logic [6:0] i2c_addr;
  int bad_count = 0;
  int checked = 0;
  always #5 clk = ~clk;
  ohi_if i_ohi_if ();
  ohi_device i_ohi_device (.i_clk(clk), .i_arst_n(arst_n), .pins(i_ohi_if.dev),
    .i_read_data(rdata), .o_data(d_data), .o_data_valid(d_valid), .o_cmd(c_cmd),
    .o_cmd_valid(c_valid), .o_read_taken(), .o_in_init(in_init), .o_mode(dmode),
    .o_i2c_addr(i2c_addr));
  ohi_host i_ohi_host (.i_clk(clk), .i_arst_n(arst_n), .pins(i_ohi_if.host), .i_mode(mode),
    .i_init_req(init_req), .i_req(req), .i_rd(rd), .i_is_data(is_data), .i_byte(byte_in),
    .o_busy(), .o_done(done), .o_rd_data(rd_data));
  ohi_asserts i_ohi_asserts (.i_clk(clk), .i_arst_n(arst_n),
    .iface_sel_low(i_ohi_if.iface_sel_low), .iface_sel_high(i_ohi_if.iface_sel_high),
    .select_n(i_ohi_if.select_n), .init_n(i_ohi_if.init_n),
    .enable_rd_n(i_ohi_if.enable_rd_n), .dir_wr_n(i_ohi_if.dir_wr_n),
    .data_host_oe_n(i_ohi_if.data_host_oe_n), .data_dev_oe_n(i_ohi_if.data_dev_oe_n),
    .scan_period_marker(i_ohi_if.scan_period_marker));
  // Valid flags may be single pulses, so latch what they carry
  always @(posedge clk) begin
    if (d_valid === 1'b1) got_d = d_data;
    if (c_valid === 1'b1) got_c = c_cmd;
  end
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expire(input int n);
    if (n >= 400) begin
      bad_count++;
      $display("ERROR timeout expected 1 seen 0");
      report_and_stop();
    end
  endtask
  task automatic xfer(input logic r, input logic d, input logic [7:0] b);
    int n;
    rd = r;
    is_data = d;
    byte_in = b;
    req = 1'b1;
    step(1);
    req = 1'b0;
    for (n = 0; n < 400 && done !== 1'b1; n++) step(1);
    expire(n);
    step(3);
  endtask
  // Both captures are cleared so a misrouted byte shows up
  task automatic wr(input logic d, input logic [7:0] b);
    got_d = 8'h00;
    got_c = 8'h00;
    xfer(1'b0, d, b);
    chk("data byte", d ? b : 8'h00, got_d);
    chk("command byte", d ? 8'h00 : b, got_c);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [7:0] b;
    int n;
    for (int m = 0; m < 4; m++) begin
      arst_n = 1'b0;
      mode = m[1:0];
      step(6);
      arst_n = 1'b1;
      step(4);
      chk("mode", {6'h00, mode}, {6'h00, dmode});
      chk("init idle", 8'h00, {7'h00, in_init});
      if (mode == ohi_pkg::SEL_I2C) begin
        b = {1'b0, ohi_pkg::I2C_ADDR_HI, i_ohi_if.cmd_or_data_sel};
        chk("i2c address", b, {1'b0, i2c_addr});
      end else begin
        b = 8'hA5 ^ {6'h00, mode};
        wr(1'b1, b);
        wr(1'b0, ~b);
        wr(1'b1, 8'hFF);
        if (mode != ohi_pkg::SEL_SERIAL) begin
          rdata = ~b ^ 8'h3C;
          xfer(1'b1, 1'b1, 8'h00);
          chk("read data", rdata, rd_data);
        end
      end
    end
    init_req = 1'b1;
    step(1);
    init_req = 1'b0;
    for (n = 0; n < 400 && in_init !== 1'b1; n++) step(1);
    expire(n);
    chk("init entered", 8'h01, {7'h00, in_init});
    report_and_stop();
  end
endmodule
`default_nettype wire
